// file: hw/mis_pkg.sv
// Shared types and constants for the instruction slice of the 8-bit core.
// Assumes a single core clock and an upstream decoder that fills mis_instr_t.
`default_nettype none
package mis_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int MIS_DATA_W = 8;
  localparam int MIS_PC_W = 10;
  localparam int MIS_PAGE_ADDR_W = 4;
  localparam int MIS_STACK_DEPTH = 8;
  localparam int MIS_SP_W = 3;
  localparam logic [7:0] MIS_ACC_RST = 8'h00;
  localparam logic [9:0] MIS_PC_RST = 10'h000;
  localparam logic [9:0] MIS_PC_STEP = 10'h001;
  localparam logic [2:0] MIS_SP_RST = 3'h0;
  localparam logic [2:0] MIS_SP_STEP = 3'h1;
  localparam logic [7:0] MIS_PAGE_RST = 8'h00;
  // Lowest second-page register that the read instruction may name.
  localparam logic [3:0] MIS_READ_LOW_ADDR = 4'h5;

  // ----------------------------------------------------------------
  // Operations and the decoded instruction carrier
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MIS_OP_NONE,
    MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR,
    MIS_OP_READ_SECOND_PAGE_REGISTER,
    MIS_OP_WRITE_SECOND_PAGE_REGISTER,
    MIS_OP_LONG_SUBROUTINE_CALL
  } mis_op_t;

  typedef struct packed {
    logic valid;
    mis_op_t op;
    logic [7:0] imm;
    logic [3:0] page_addr;
    logic [9:0] target;
  } mis_instr_t;

  typedef enum logic {
    MIS_ST_RUN,
    MIS_ST_CALL_LOAD
  } mis_state_t;

endpackage
`default_nettype wire

// file: hw/mis_page_regs.sv
// Second-page special register file: sixteen 8-bit entries.
// Assumes writes arrive as single-cycle strobes from the instruction slice.
`timescale 1ns/1ps
`default_nettype none
module mis_page_regs
  import mis_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] page_q [16];
  logic [7:0] page_d [16];

  // ----------------------------------------------------------------
  // One register per entry
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_entry
    // The entry takes the accumulator only when its own address is written.
    always_comb begin
      page_d[i] = page_q[i];
      if (wr_en && (wr_addr == 4'(i))) begin
        page_d[i] = wr_data;
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        page_q[i] <= MIS_PAGE_RST;
      end else begin
        page_q[i] <= page_d[i];
      end
    end
  end

  // Reads are combinational so the slice can finish in one cycle.
  assign rd_data = page_q[rd_addr];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_page_write_lands: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_en |=> page_q[$past(wr_addr)] == $past(wr_data))
    else $error("second-page write did not land in one cycle");

endmodule
`default_nettype wire

// file: hw/mis_slice.sv
// Execution slice for four instructions of the 8-bit core: immediate OR,
// second-page register read and write, and the long subroutine call.
// Assumes the decoder presents one instruction while ready_q is high.
`timescale 1ns/1ps
`default_nettype none
module mis_slice
  import mis_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire mis_instr_t instr,
  output logic ready_q,
  output logic [7:0] acc_q,
  output logic zero_q,
  output logic [9:0] pc_q,
  output logic [2:0] sp_q,
  output logic [9:0] top_of_stack_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mis_state_t state_q, state_d;
  logic ready_d;
  logic [7:0] acc_d;
  logic zero_d;
  logic [9:0] pc_d;
  logic [2:0] sp_d;
  logic [9:0] target_q, target_d;
  logic [9:0] stack_q [MIS_STACK_DEPTH];
  logic [9:0] stack_d [MIS_STACK_DEPTH];
  logic [9:0] tos_d;
  logic take;
  logic page_wr;
  logic [7:0] page_rd_data;
  logic [7:0] or_result;

  assign take = instr.valid && ready_q;
  assign or_result = acc_q | instr.imm;
  assign page_wr = take && (instr.op == MIS_OP_WRITE_SECOND_PAGE_REGISTER);

  // ----------------------------------------------------------------
  // Second-page register file
  // ----------------------------------------------------------------
  mis_page_regs u_page (
    .core_clk(core_clk),
    .resetn(resetn),
    .wr_en(page_wr),
    .wr_addr(instr.page_addr),
    .wr_data(acc_q),
    .rd_addr(instr.page_addr),
    .rd_data(page_rd_data)
  );

  // ----------------------------------------------------------------
  // Sequencing, accumulator and program counter
  // ----------------------------------------------------------------
  // A call is split over two cycles: the push first, the jump second,
  // so that the return address is safe before the counter moves.
  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    acc_d = acc_q;
    zero_d = zero_q;
    pc_d = pc_q;
    sp_d = sp_q;
    target_d = target_q;
    unique case (state_q)
      MIS_ST_RUN: begin
        if (take) begin
          pc_d = pc_q + MIS_PC_STEP;
          unique case (instr.op)
            MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR: begin
              acc_d = or_result;
              zero_d = (or_result == MIS_ACC_RST);
            end
            MIS_OP_READ_SECOND_PAGE_REGISTER: begin
              // Entries below the low bound are not readable; such a read is a no-op.
              if (instr.page_addr >= MIS_READ_LOW_ADDR) begin
                acc_d = page_rd_data;
              end
            end
            MIS_OP_LONG_SUBROUTINE_CALL: begin
              pc_d = pc_q; // Held until the target is loaded.
              sp_d = sp_q + MIS_SP_STEP;
              target_d = instr.target;
              state_d = MIS_ST_CALL_LOAD;
              ready_d = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      MIS_ST_CALL_LOAD: begin
        pc_d = target_q;
        state_d = MIS_ST_RUN;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= MIS_ST_RUN;
      ready_q <= 1'b1;
      acc_q <= MIS_ACC_RST;
      zero_q <= 1'b0;
      pc_q <= MIS_PC_RST;
      sp_q <= MIS_SP_RST;
      target_q <= MIS_PC_RST;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      acc_q <= acc_d;
      zero_q <= zero_d;
      pc_q <= pc_d;
      sp_q <= sp_d;
      target_q <= target_d;
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  // The pointer wraps past the last level; deeper nesting overwrites the
  // oldest entry, as software must keep calls within the stack depth.
  for (genvar i = 0; i < MIS_STACK_DEPTH; i++) begin : g_stack
    always_comb begin
      stack_d[i] = stack_q[i];
      if (take && (instr.op == MIS_OP_LONG_SUBROUTINE_CALL) && (sp_q == 3'(i))) begin
        stack_d[i] = pc_q + MIS_PC_STEP;
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        stack_q[i] <= MIS_PC_RST;
      end else begin
        stack_q[i] <= stack_d[i];
      end
    end
  end

  // Mirror of the newest entry, for observation.
  always_comb begin
    tos_d = top_of_stack_q;
    if (take && (instr.op == MIS_OP_LONG_SUBROUTINE_CALL)) begin
      tos_d = pc_q + MIS_PC_STEP;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      top_of_stack_q <= MIS_PC_RST;
    end else begin
      top_of_stack_q <= tos_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_or_acc_zero: assert property (
    take && instr.op == MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR |=>
      acc_q == ($past(acc_q) | $past(instr.imm)) && zero_q == (acc_q == 8'h00) && ready_q)
    else $error("immediate OR result or zero flag wrong");

  chk_read_copy_flags: assert property (
    take && instr.op == MIS_OP_READ_SECOND_PAGE_REGISTER && instr.page_addr >= MIS_READ_LOW_ADDR |=>
      acc_q == $past(page_rd_data) && $stable(zero_q) && ready_q)
    else $error("page read did not copy register or touched flags");

  chk_write_one_cycle: assert property (
    take && instr.op == MIS_OP_WRITE_SECOND_PAGE_REGISTER |=> ready_q && $stable(acc_q)
      && pc_q == $past(pc_q) + MIS_PC_STEP)
    else $error("page write did not finish in one cycle");

  chk_call_push: assert property (
    take && instr.op == MIS_OP_LONG_SUBROUTINE_CALL |=>
      stack_q[$past(sp_q)] == $past(pc_q) + MIS_PC_STEP && top_of_stack_q == $past(pc_q) + MIS_PC_STEP)
    else $error("call did not push return address");

  chk_call_target: assert property (
    take && instr.op == MIS_OP_LONG_SUBROUTINE_CALL |=> !ready_q ##1 ready_q && pc_q == $past(instr.target, 2))
    else $error("call target not loaded after two cycles");

  chk_call_level: assert property (
    take && instr.op == MIS_OP_LONG_SUBROUTINE_CALL |=> sp_q == $past(sp_q) + MIS_SP_STEP ##1 $stable(sp_q))
    else $error("stack pointer did not advance by one level");

  chk_low_read_noop: assert property (
    take && instr.op == MIS_OP_READ_SECOND_PAGE_REGISTER && instr.page_addr < MIS_READ_LOW_ADDR |=>
      $stable(acc_q) && $stable(zero_q) && pc_q == $past(pc_q) + MIS_PC_STEP)
    else $error("page read below the low bound changed the accumulator");

  chk_stall_ignored: assert property (
    !ready_q |=> ready_q && $stable(acc_q) && $stable(zero_q) && $stable(sp_q))
    else $error("instruction taken during the call stall");

  chk_single_step: assert property (
    take && instr.op != MIS_OP_LONG_SUBROUTINE_CALL |=> ready_q && pc_q == $past(pc_q) + MIS_PC_STEP)
    else $error("single-cycle instruction did not advance the counter by one");

  cov_or_zero: cover property (take && instr.op == MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR ##1 zero_q);
  cov_read_then_write: cover property (take && instr.op == MIS_OP_READ_SECOND_PAGE_REGISTER
    ##1 take && instr.op == MIS_OP_WRITE_SECOND_PAGE_REGISTER);
  cov_call_back_to_back: cover property (take && instr.op == MIS_OP_LONG_SUBROUTINE_CALL
    ##2 take && instr.op == MIS_OP_LONG_SUBROUTINE_CALL);
  cov_low_read: cover property (take && instr.op == MIS_OP_READ_SECOND_PAGE_REGISTER
    && instr.page_addr < MIS_READ_LOW_ADDR);

endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the instruction slice of the 8-bit core.
// Assumes mis_pkg and mis_slice are compiled first; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mis_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, reset and the design
  // ----------------------------------------------------------------
  logic core_clk, resetn, ready_q, zero_q;
  mis_instr_t instr;
  logic [7:0] acc_q, e_acc;
  logic [9:0] pc_q, top_of_stack_q, e_pc, e_tos;
  logic [2:0] sp_q, e_sp;
  logic e_zero;
  logic [7:0] e_page [16];
  int bad_count = 0;
  int checked = 0;

  // Free-running 25 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  mis_slice i_dut (.core_clk(core_clk), .resetn(resetn), .instr(instr), .ready_q(ready_q), .acc_q(acc_q),
    .zero_q(zero_q), .pc_q(pc_q), .sp_q(sp_q), .top_of_stack_q(top_of_stack_q));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Reports the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compares one value; case inequality so an unknown never matches.
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Compares every visible output with the bench's own model.
  task automatic check_all(input logic e_ready);
    cmp(10'(acc_q), 10'(e_acc));
    cmp(10'(zero_q), 10'(e_zero));
    cmp(pc_q, e_pc);
    cmp(10'(sp_q), 10'(e_sp));
    cmp(top_of_stack_q, e_tos);
    cmp(10'(ready_q), 10'(e_ready));
  endtask

  // Presents one single-cycle instruction, lets it be taken, updates the model.
  task automatic step(input mis_op_t op, input logic [7:0] imm, input logic [3:0] addr);
    instr = '{valid: 1'b1, op: op, imm: imm, page_addr: addr, target: 10'h000};
    @(negedge core_clk);
    case (op)
      MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR: begin
        e_acc = e_acc | imm;
        e_zero = (e_acc == 8'h00);
      end
      MIS_OP_READ_SECOND_PAGE_REGISTER: if (addr >= 4'h5) e_acc = e_page[addr];
      MIS_OP_WRITE_SECOND_PAGE_REGISTER: e_page[addr] = e_acc;
      default: ;
    endcase
    e_pc = e_pc + 10'h001;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Back-to-back immediate OR, the first giving a zero result.
  task automatic t_or();
    logic [7:0] imms [4] = '{8'h00, 8'h50, 8'hAA, 8'h00};
    foreach (imms[i]) begin
      step(MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR, imms[i], 4'h0);
      check_all(1'b1);
    end
  endtask

  // Page writes at both ends of the range, reads with the flag held, a refused low read.
  task automatic t_page();
    step(MIS_OP_WRITE_SECOND_PAGE_REGISTER, 8'h00, 4'hF);
    check_all(1'b1);
    step(MIS_OP_WRITE_SECOND_PAGE_REGISTER, 8'h00, 4'h0);
    check_all(1'b1);
    step(MIS_OP_READ_SECOND_PAGE_REGISTER, 8'h00, 4'h5);
    check_all(1'b1);
    step(MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR, 8'h0C, 4'h0);
    check_all(1'b1);
    step(MIS_OP_WRITE_SECOND_PAGE_REGISTER, 8'h00, 4'h5);
    check_all(1'b1);
    step(MIS_OP_READ_SECOND_PAGE_REGISTER, 8'h00, 4'hF);
    check_all(1'b1);
    step(MIS_OP_READ_SECOND_PAGE_REGISTER, 8'h00, 4'h4);
    check_all(1'b1);
    step(MIS_OP_READ_SECOND_PAGE_REGISTER, 8'h00, 4'h5);
    check_all(1'b1);
    step(MIS_OP_WRITE_SECOND_PAGE_REGISTER, 8'h00, 4'h3);
    check_all(1'b1);
  endtask

  // A mid-run reset clears the core state and the page entries; a read is taken at the first edge.
  task automatic t_reset();
    instr = '0;
    resetn = 1'b0;
    @(negedge core_clk);
    e_acc = 8'h00;
    e_zero = 1'b0;
    e_pc = 10'h000;
    e_sp = 3'h0;
    e_tos = 10'h000;
    foreach (e_page[i]) e_page[i] = 8'h00;
    check_all(1'b1);
    resetn = 1'b1;
    step(MIS_OP_READ_SECOND_PAGE_REGISTER, 8'h00, 4'h5);
    check_all(1'b1);
  endtask

  // Nine calls in a row wrap the stack level; an OR offered in the stall must be ignored.
  task automatic t_call();
    logic [9:0] tgt;
    for (int i = 0; i < 9; i++) begin
      tgt = (i == 0) ? 10'h3FF : 10'(i * 113);
      instr = '{valid: 1'b1, op: MIS_OP_LONG_SUBROUTINE_CALL, imm: 8'h00, page_addr: 4'h0, target: tgt};
      @(negedge core_clk);
      e_tos = e_pc + 10'h001;
      e_sp = e_sp + 3'h1;
      check_all(1'b0);
      instr = '{valid: 1'b1, op: MIS_OP_OR_IMMEDIATE_INTO_ACCUMULATOR, imm: 8'hFF, page_addr: 4'h0, target: 10'h000};
      @(negedge core_clk);
      e_pc = tgt;
      check_all(1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    instr = '0;
    e_acc = 8'h00;
    e_zero = 1'b0;
    e_pc = 10'h000;
    e_sp = 3'h0;
    e_tos = 10'h000;
    foreach (e_page[i]) e_page[i] = 8'h00;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    check_all(1'b1);
    t_or();
    t_page();
    t_call();
    t_reset();
    instr = '0;
    @(negedge core_clk);
    end_sim();
  end

  // The tests need well under a hundred cycles; this limit only cuts a hang.
  initial begin
    #(40 * 2000);
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
